// ===== rtl/jfp_top.sv
// jfp_top: nv memory access over the test port indirect registers
// assumes a test-port controller on link_clk_in with capture/shift/update strobes,
// and an nv array on ref_clk_in answering with mem_done_in
`timescale 1ns/10ps
`include "jfp_map.svh"

module jfp_top
  import jfp_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic rst_in, // synchronous reset, active high
  input wire logic link_clk_in, // test clock
  input wire logic [1:0] link_sel_in, // indirect register selected by instruction
  input wire logic link_capture_in, // capture-dr strobe
  input wire logic link_shift_in, // shift-dr strobe
  input wire logic link_update_in, // update-dr strobe
  input wire logic link_tdi_in, // serial data in
  output logic link_tdo_out, // serial data out
  output logic [15:0] mem_addr_out, // array byte address
  output logic [7:0] mem_wdata_out, // array program data
  output logic mem_rd_strobe_out, // array read strobe
  output logic mem_wr_out, // array program pulse
  output logic mem_erase_out, // array page erase pulse
  output logic mem_oneshot_out, // strobe shaping select
  output logic mem_sense_en_out, // output enable and sense amps
  output logic [3:0] mem_prescale_out, // array timing prescaler
  input wire logic [7:0] mem_rdata_in, // array read data
  input wire logic mem_done_in, // array operation complete
  input wire logic mem_fail_in // array operation failed
);

  localparam int ONESHOT_CYC_RAW = `JFP_ONESHOT_NS / `JFP_CLK_PERIOD_NS;
  localparam int ONESHOT_CYC = (ONESHOT_CYC_RAW < 1) ? 1 : ONESHOT_CYC_RAW;
  localparam logic [3:0] ONESHOT_LEN = 4'(ONESHOT_CYC);
  localparam logic [3:0] FULL_LEN = 4'h1;

  // link domain
  logic link_rst;
  logic [`JFP_FRAME_W-1:0] shreg_q;
  logic cap_busy_q;
  logic pending_q;
  logic req_tgl_q;
  logic ack_seen_q;
  logic ack_sync;
  jfp_cmd_t cmd_q;
  logic cmd_issue;

  // system domain
  logic req_sync;
  logic req_seen_q;
  logic ack_tgl_q;
  logic cmd_fire;
  jfp_state_t state_q;
  logic [7:0] ctrl_q;
  logic [7:0] data_q;
  logic fail_q;
  logic busy_q;
  logic [15:0] ptr_q;
  logic [7:0] scale_q;
  logic [`JFP_WDATA_W-1:0] rdata_q;
  logic unread_q;
  logic op_read_q;
  logic op_prog_q;
  logic [3:0] strobe_cnt_q;
  jfp_mem_req_t mreq_q;
  logic [3:0] rd_sel;
  logic [3:0] wr_sel;
  logic presc_off;
  logic launch_rd;
  logic launch_wr;
  logic launch_er;
  logic launch;
  logic [`JFP_DATA_W-1:0] data_port;

  jfp_sync #(.W(1)) u_rst_sync (
    .clk_in(link_clk_in),
    .d_in(rst_in),
    .q_out(link_rst)
  );
  jfp_sync #(.W(1)) u_ack_sync (
    .clk_in(link_clk_in),
    .d_in(ack_tgl_q),
    .q_out(ack_sync)
  );
  jfp_sync #(.W(1)) u_req_sync (
    .clk_in(ref_clk_in),
    .d_in(req_tgl_q),
    .q_out(req_sync)
  );

  // link side: shift register, lsb leaves first
  // answer frame layout
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      shreg_q <= '0;
      cap_busy_q <= 1'b1;
    end else if (link_capture_in) begin
      // rdata_q only moves while pending_q is high, so it is quasi-static here
      shreg_q <= {1'b0, rdata_q, pending_q};
      cap_busy_q <= pending_q;
    end else if (link_shift_in) begin
      shreg_q <= {link_tdi_in, shreg_q[`JFP_FRAME_W-1:1]};
    end
  end

  assign link_tdo_out = shreg_q[0];

  // opcode decode, short shifts leave data left-justified
  // only a capture that saw busy low arms an update
  assign cmd_issue = link_update_in && shreg_q[`JFP_OPC_HI] && !cap_busy_q && !pending_q;

  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      cmd_q <= '0;
      req_tgl_q <= 1'b0;
    end else if (cmd_issue) begin
      cmd_q.is_write <= shreg_q[`JFP_OPC_LO];
      cmd_q.sel <= link_sel_in;
      cmd_q.wdata <= shreg_q[`JFP_WDATA_W-1:0];
      req_tgl_q <= ~req_tgl_q;
    end
  end

  // pending covers the crossing and the whole operation
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      pending_q <= 1'b0;
      ack_seen_q <= 1'b0;
    end else begin
      ack_seen_q <= ack_sync;
      if (cmd_issue) begin
        pending_q <= 1'b1;
      end else if (ack_sync != ack_seen_q) begin
        pending_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      req_seen_q <= 1'b0;
    end else begin
      req_seen_q <= req_sync;
    end
  end

  assign cmd_fire = (req_sync != req_seen_q) && (state_q == JFP_IDLE);
  assign rd_sel = ctrl_q[`JFP_RD_SEL_HI:`JFP_RD_SEL_LO];
  assign wr_sel = ctrl_q[`JFP_WR_SEL_HI:`JFP_WR_SEL_LO];
  // prescale all ones refuses every launch
  assign presc_off = (scale_q[`JFP_PRESC_HI:`JFP_PRESC_LO] == `JFP_PRESC_OFF);

  always_comb begin
    launch_rd = 1'b0;
    if (cmd_fire && !cmd_q.is_write && cmd_q.sel == `JFP_SEL_DATA && !presc_off) begin
      unique case (rd_sel)
        `JFP_RD_EVERY: launch_rd = 1'b1;
        `JFP_RD_ONCE: launch_rd = !unread_q;
        default: launch_rd = 1'b0;
      endcase
    end
  end
  always_comb begin
    launch_wr = 1'b0;
    launch_er = 1'b0;
    if (cmd_fire && cmd_q.is_write && cmd_q.sel == `JFP_SEL_DATA && !presc_off) begin
      unique case (wr_sel)
        `JFP_WR_PROG: launch_wr = 1'b1;
        `JFP_WR_ERASE: launch_er = (cmd_q.wdata[`JFP_WDATA_W-1 -: 8] == `JFP_ERASE_KEY);
        default: launch_wr = 1'b0;
      endcase
    end
  end

  assign launch = launch_rd || launch_wr || launch_er;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= JFP_IDLE;
      busy_q <= 1'b0;
      ack_tgl_q <= 1'b0;
    end else begin
      unique case (state_q)
        JFP_IDLE: begin
          if (cmd_fire) begin
            busy_q <= 1'b1;
            state_q <= launch ? JFP_RUN : JFP_FIN;
          end
        end
        JFP_RUN: begin
          if (mem_done_in && strobe_cnt_q == 4'h0) begin
            state_q <= JFP_FIN;
          end
        end
        JFP_FIN: begin
          busy_q <= 1'b0;
          ack_tgl_q <= ~ack_tgl_q;
          state_q <= JFP_IDLE;
        end
      endcase
    end
  end

  // strobe length from the one-shot select
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mreq_q <= '0;
      strobe_cnt_q <= 4'h0;
      op_read_q <= 1'b0;
      op_prog_q <= 1'b0;
    end else begin
      mreq_q.wr <= launch_wr;
      mreq_q.erase <= launch_er;
      if (launch) begin
        mreq_q.addr <= ptr_q;
        mreq_q.wdata <= cmd_q.wdata[`JFP_WDATA_W-1 -: 8];
        op_read_q <= launch_rd;
        op_prog_q <= launch_wr;
      end
      if (launch_rd) begin
        mreq_q.rd <= 1'b1;
        strobe_cnt_q <= scale_q[`JFP_ONESHOT_BIT] ? ONESHOT_LEN : FULL_LEN;
      end else if (strobe_cnt_q > 4'h1) begin
        strobe_cnt_q <= strobe_cnt_q - 4'h1;
      end else begin
        strobe_cnt_q <= 4'h0;
        mreq_q.rd <= 1'b0;
      end
    end
  end

  // zero reset of the data port
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_q <= `JFP_CTRL_RST;
      data_q <= 8'(`JFP_DATA_RST >> `JFP_DATA_BYTE_LO);
      ptr_q <= `JFP_PTR_RST;
      scale_q <= `JFP_SCALE_RST;
    end else if (cmd_fire && cmd_q.is_write) begin
      unique case (cmd_q.sel)
        `JFP_SEL_CTRL: ctrl_q <= cmd_q.wdata[`JFP_WDATA_W-1 -: 8];
        // write action 0000 only stores the byte
        `JFP_SEL_DATA: data_q <= cmd_q.wdata[`JFP_WDATA_W-1 -: 8];
        `JFP_SEL_PTR: ptr_q <= cmd_q.wdata[`JFP_WDATA_W-1 -: 16];
        `JFP_SEL_SCALE: scale_q <= cmd_q.wdata[`JFP_WDATA_W-1 -: 8] & `JFP_SCALE_KEEP;
      endcase
    end else if (state_q == JFP_RUN && mem_done_in && strobe_cnt_q == 4'h0) begin
      if (op_read_q) begin
        data_q <= mem_rdata_in;
      end
      // pointer bumps once the byte is programmed
      if (op_prog_q) begin
        ptr_q <= ptr_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      fail_q <= 1'b0;
    end else if (state_q == JFP_RUN && mem_done_in && strobe_cnt_q == 4'h0) begin
      fail_q <= mem_fail_in;
    end else if (cmd_fire && cmd_q.sel == `JFP_SEL_DATA && presc_off &&
                 (cmd_q.is_write ? (wr_sel != `JFP_WR_HOLD) : (rd_sel != `JFP_RD_HOLD))) begin
      // a refused operation counts as failed
      fail_q <= 1'b1;
    end
  end

  // unfetched result tracking; a new result wins over the fetch
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      unread_q <= 1'b0;
    end else if (state_q == JFP_RUN && mem_done_in && strobe_cnt_q == 4'h0 && op_read_q) begin
      unread_q <= 1'b1;
    end else if (cmd_fire && !cmd_q.is_write && cmd_q.sel == `JFP_SEL_DATA) begin
      unread_q <= 1'b0;
    end
  end

  assign data_port = {data_q, fail_q, busy_q};

  // read answer carries the held value, right-justified
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_q <= '0;
    end else if (cmd_fire && !cmd_q.is_write) begin
      unique case (cmd_q.sel)
        `JFP_SEL_CTRL: rdata_q <= {10'h000, ctrl_q};
        `JFP_SEL_DATA: rdata_q <= {8'h00, data_port};
        `JFP_SEL_PTR: rdata_q <= {2'h0, ptr_q};
        `JFP_SEL_SCALE: rdata_q <= {10'h000, scale_q};
      endcase
    end
  end

  assign mem_addr_out = mreq_q.addr;
  assign mem_wdata_out = mreq_q.wdata;
  assign mem_rd_strobe_out = mreq_q.rd;
  assign mem_wr_out = mreq_q.wr;
  assign mem_erase_out = mreq_q.erase;
  assign mem_oneshot_out = scale_q[`JFP_ONESHOT_BIT];
  assign mem_prescale_out = scale_q[`JFP_PRESC_HI:`JFP_PRESC_LO];
  // sense amps on for reads, or always
  assign mem_sense_en_out = scale_q[`JFP_SENSE_BIT] || (state_q == JFP_RUN && op_read_q);

  a_hold_no_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (cmd_fire && !cmd_q.is_write && cmd_q.sel == `JFP_SEL_DATA && rd_sel == `JFP_RD_HOLD)
      |=> !mem_rd_strobe_out && state_q == JFP_FIN)
    else $error("hold mode read launched an access");
  a_every_read_go: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (cmd_fire && !cmd_q.is_write && cmd_q.sel == `JFP_SEL_DATA && rd_sel == `JFP_RD_EVERY && !presc_off)
      |=> mem_rd_strobe_out && busy_q)
    else $error("block read mode did not launch");
  a_once_no_extra: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (cmd_fire && rd_sel == `JFP_RD_ONCE && unread_q) |=> !mem_rd_strobe_out)
    else $error("single read mode launched a surplus read");
  a_reset_port_zero: assert property (@(posedge ref_clk_in)
    $fell(rst_in) |-> data_port == `JFP_DATA_RST && scale_q == `JFP_SCALE_RST)
    else $error("data port or scale not zero after reset");
  a_fail_outcome: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state_q == JFP_RUN && mem_done_in && strobe_cnt_q == 4'h0) |=> fail_q == $past(mem_fail_in))
    else $error("fail flag does not match outcome");
  a_unused_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (scale_q & ~`JFP_SCALE_KEEP) == 8'h00)
    else $error("unused scale bits not zero");
  a_prescale_refuse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    presc_off |=> !mem_wr_out && !mem_erase_out && !$rose(mem_rd_strobe_out))
    else $error("operation launched with prescale off");
  a_ptr_bump: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state_q == JFP_RUN && op_prog_q && mem_done_in && strobe_cnt_q == 4'h0)
      |=> ptr_q == $past(ptr_q) + 16'h0001)
    else $error("pointer not bumped after program");
  a_erase_key: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    mem_erase_out |-> $past(cmd_q.wdata[`JFP_WDATA_W-1 -: 8]) == `JFP_ERASE_KEY && $stable(ptr_q))
    else $error("erase without key");
  a_busy_ignore: assert property (@(posedge link_clk_in) disable iff (link_rst)
    (link_update_in && cap_busy_q) |=> $stable(req_tgl_q) && $stable(cmd_q))
    else $error("command taken while busy");
  a_busy_launch: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    launch |=> busy_q && state_q == JFP_RUN ##1 busy_q)
    else $error("busy not raised at launch");

endmodule

// ===== rtl/jfp_map.svh
// jfp_map.svh: offsets, field positions, codes and timing of the nv access port
// assumes inclusion by bare name from the package and the main module
`ifndef JFP_MAP_SVH
`define JFP_MAP_SVH

// indirect register selects, as presented by the test port's instruction decode
`define JFP_SEL_CTRL 2'h0
`define JFP_SEL_DATA 2'h1
`define JFP_SEL_PTR 2'h2
`define JFP_SEL_SCALE 2'h3

// indirect command and answer frame
`define JFP_FRAME_W 20
`define JFP_OPC_HI 19
`define JFP_OPC_LO 18
`define JFP_WDATA_W 18
`define JFP_OP_READ 2'h2
`define JFP_OP_WRITE 2'h3

// mode control fields
`define JFP_WR_SEL_HI 7
`define JFP_WR_SEL_LO 4
`define JFP_RD_SEL_HI 3
`define JFP_RD_SEL_LO 0
`define JFP_RD_HOLD 4'h0
`define JFP_RD_EVERY 4'h1
`define JFP_RD_ONCE 4'h2
`define JFP_WR_HOLD 4'h0
`define JFP_WR_PROG 4'h1
`define JFP_WR_ERASE 4'h2
`define JFP_ERASE_KEY 8'ha5

// data port layout
`define JFP_DATA_W 10
`define JFP_DATA_BYTE_HI 9
`define JFP_DATA_BYTE_LO 2
`define JFP_FAIL_BIT 1
`define JFP_BUSY_BIT 0

// timing scale layout
`define JFP_ONESHOT_BIT 7
`define JFP_SENSE_BIT 6
`define JFP_SCALE_KEEP 8'hcf
`define JFP_PRESC_HI 3
`define JFP_PRESC_LO 0
`define JFP_PRESC_OFF 4'hf

// reset values
`define JFP_CTRL_RST 8'h00
`define JFP_DATA_RST 10'h000
`define JFP_PTR_RST 16'h0000
`define JFP_SCALE_RST 8'h00

// timing
`define JFP_CLK_PERIOD_NS 100
`define JFP_ONESHOT_NS 50

`endif

// ===== rtl/jfp_pkg.sv
// jfp_pkg: types shared by the nv access port
// assumes jfp_map.svh is on the include path
`include "jfp_map.svh"

package jfp_pkg;

  typedef enum logic [2:0] {
    JFP_IDLE = 3'b001,
    JFP_RUN = 3'b010,
    JFP_FIN = 3'b100
  } jfp_state_t;

  typedef struct packed {
    logic is_write;
    logic [1:0] sel;
    logic [`JFP_WDATA_W-1:0] wdata;
  } jfp_cmd_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
    logic erase;
  } jfp_mem_req_t;

endpackage

// ===== rtl/jfp_sync.sv
// jfp_sync: two flip-flop level synchroniser, one per bit
// assumes the input is a level, stable for several destination clocks
`timescale 1ns/10ps

module jfp_sync #(
  parameter int W = 1
) (
  input wire logic clk_in, // destination clock
  input wire logic [W-1:0] d_in, // level from the far domain
  output logic [W-1:0] q_out // synchronised level
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    meta_q <= d_in;
    sync_q <= meta_q;
  end

  assign q_out = sync_q;

endmodule

// ===== verif/jfp_array_model.sv
// jfp_array_model: behavioural nv array answering the access port's strobes
// assumes one operation at a time, all on the system clock
`timescale 1ns/10ps

module jfp_array_model (
  input wire logic clk_in, // system clock
  input wire logic [15:0] addr_in, // byte address
  input wire logic [7:0] wdata_in, // program data
  input wire logic rd_in, // read strobe
  input wire logic wr_in, // program pulse
  input wire logic erase_in, // erase pulse
  output logic [7:0] rdata_out, // read data, valid with done
  output logic done_out, // operation complete
  output logic fail_out // operation failed
);
  logic [7:0] mem [256];
  logic [15:0] addr_q;
  int cnt;

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    cnt = 0;
    addr_q = 16'h0000;
    done_out = 1'b0;
    fail_out = 1'b0;
    rdata_out = 8'h00;
  end

  always @(posedge clk_in) begin
    done_out <= 1'b0;
    fail_out <= 1'b0;
    // bus not driven outside done, so keep it moving
    rdata_out <= ~rdata_out;
    if (rd_in || wr_in || erase_in) begin
      // answer promptly or slowly
      cnt <= $urandom_range(8, 1);
      addr_q <= addr_in;
      if (wr_in && !addr_in[15])
        mem[addr_in[7:0]] <= wdata_in;
      if (erase_in && !addr_in[15]) begin
        foreach (mem[i]) mem[i] <= 8'hff;
      end
    end else if (cnt == 1) begin
      cnt <= 0;
      done_out <= 1'b1;
      rdata_out <= mem[addr_q[7:0]];
      fail_out <= addr_q[15];
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ===== verif/testbench.sv
// testbench: drives the test-port controller side and checks the nv access port
// assumes jfp_map.svh on the include path; array side is jfp_array_model
`timescale 1ns/10ps
`include "jfp_map.svh"

module testbench;
  import jfp_pkg::*;
  logic ref_clk_in, rst_in, link_clk_in, link_capture_in, link_shift_in, link_update_in, link_tdi_in;
  logic [1:0] link_sel_in;
  logic link_tdo_out, mem_rd_strobe_out, mem_wr_out, mem_erase_out, mem_oneshot_out, mem_sense_en_out;
  logic [15:0] mem_addr_out;
  logic [7:0] mem_wdata_out, mem_rdata_in;
  logic [3:0] mem_prescale_out;
  logic mem_done_in, mem_fail_in;
  int fails = 0;
  int comparisons = 0;
  int n_rd = 0;
  int n_er = 0;
  int s;
  logic [17:0] v;
  logic [19:0] g;
  logic [7:0] b [4];

  jfp_top uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in), .link_sel_in(link_sel_in),
    .link_capture_in(link_capture_in), .link_shift_in(link_shift_in), .link_update_in(link_update_in),
    .link_tdi_in(link_tdi_in), .link_tdo_out(link_tdo_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_rd_strobe_out(mem_rd_strobe_out), .mem_wr_out(mem_wr_out),
    .mem_erase_out(mem_erase_out), .mem_oneshot_out(mem_oneshot_out), .mem_sense_en_out(mem_sense_en_out),
    .mem_prescale_out(mem_prescale_out), .mem_rdata_in(mem_rdata_in), .mem_done_in(mem_done_in),
    .mem_fail_in(mem_fail_in));

  jfp_array_model array (.clk_in(ref_clk_in), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
    .rd_in(mem_rd_strobe_out), .wr_in(mem_wr_out), .erase_in(mem_erase_out), .rdata_out(mem_rdata_in),
    .done_out(mem_done_in), .fail_out(mem_fail_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    link_clk_in = 1'b0;
    #17;
    forever #32 link_clk_in = ~link_clk_in;
  end

  // pulses counted mid-cycle, where they have settled
  always @(negedge ref_clk_in) begin
    if (mem_rd_strobe_out === 1'b1) n_rd++;
    if (mem_erase_out === 1'b1) n_er++;
  end

  function automatic logic [17:0] exp_scale(input logic [7:0] w);
    return {10'h000, w & 8'hcf};
  endfunction

  task automatic end_of_test();
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // capture, n shifts with tdo taken mid-cycle, optional update; driven on rising edges
  task automatic frame(input logic [1:0] sel, input logic [19:0] cmd, input int n, input bit upd,
                       output logic [19:0] got);
    got = 20'h00000;
    @(posedge link_clk_in);
    link_sel_in <= sel;
    link_capture_in <= 1'b1;
    @(posedge link_clk_in);
    link_capture_in <= 1'b0;
    for (int i = 0; i < n; i++) begin
      link_shift_in <= 1'b1;
      link_tdi_in <= cmd[20-n+i];
      @(negedge link_clk_in);
      got[i] = link_tdo_out;
      @(posedge link_clk_in);
    end
    link_shift_in <= 1'b0;
    if (upd) begin
      link_update_in <= 1'b1;
      @(posedge link_clk_in);
      link_update_in <= 1'b0;
    end
  endtask

  task automatic wait_idle(input logic [1:0] sel);
    logic [19:0] p;
    for (int k = 0; k < 300; k++) begin
      frame(sel, 20'h00000, 1, 1'b0, p);
      if (p[0] === 1'b0) return;
    end
    fails++;
    end_of_test();
  endtask

  task automatic op(input logic [1:0] sel, input bit wr, input logic [17:0] val, input int w);
    logic [19:0] p;
    frame(sel, {1'b1, wr, val << (18 - w)}, wr ? w + 2 : 2, 1'b1, p);
    wait_idle(sel);
  endtask

  task automatic rd(input logic [1:0] sel, output logic [17:0] val);
    logic [19:0] p;
    op(sel, 1'b0, 18'h00000, 0);
    frame(sel, 20'h00000, 19, 1'b0, p);
    val = p[18:1];
  endtask

  initial begin
    void'($urandom(9));
    rst_in = 1'b1;
    link_sel_in = 2'h0;
    link_capture_in = 1'b0;
    link_shift_in = 1'b0;
    link_update_in = 1'b0;
    link_tdi_in = 1'b0;
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge link_clk_in);
    rd(`JFP_SEL_DATA, v);
    chk(v, 18'h00000);
    // prescale programmed before any array work
    op(`JFP_SEL_SCALE, 1'b1, 18'h000f3, 8);
    rd(`JFP_SEL_SCALE, v);
    chk(v, exp_scale(8'hf3));
    chk({12'h000, mem_oneshot_out, mem_sense_en_out, mem_prescale_out}, 18'h00033);
    op(`JFP_SEL_SCALE, 1'b1, 18'h00003, 8);
    chk(mem_sense_en_out, 18'h0);
    // only defined action codes are used
    op(`JFP_SEL_CTRL, 1'b1, 18'h00010, 8);
    op(`JFP_SEL_PTR, 1'b1, 18'h00020, 16);
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($urandom());
      frame(`JFP_SEL_DATA, {2'b11, b[i], 10'h000}, 10, 1'b1, g);
      frame(`JFP_SEL_DATA, 20'h00000, 1, 1'b0, g);
      chk(g[0], 18'h1);
      // second program while busy must be dropped
      frame(`JFP_SEL_DATA, {2'b11, ~b[i], 10'h000}, 10, 1'b1, g);
      wait_idle(`JFP_SEL_DATA);
      rd(`JFP_SEL_PTR, v);
      chk(v, 18'h00021 + 18'(i));
    end
    op(`JFP_SEL_CTRL, 1'b1, 18'h00001, 8);
    for (int i = 0; i < 4; i++) begin
      op(`JFP_SEL_PTR, 1'b1, 18'h00020 + 18'(i), 16);
      s = n_rd;
      rd(`JFP_SEL_DATA, v);
      rd(`JFP_SEL_DATA, v);
      chk(v, {8'h00, b[i], 2'b00});
      chk(18'(n_rd - s), 18'h2);
    end
    op(`JFP_SEL_CTRL, 1'b1, 18'h00000, 8);
    s = n_rd;
    rd(`JFP_SEL_DATA, v);
    rd(`JFP_SEL_DATA, v);
    chk(18'(n_rd - s), 18'h0);
    chk(v, {8'h00, b[3], 2'b00});
    op(`JFP_SEL_CTRL, 1'b1, 18'h00002, 8);
    s = n_rd;
    repeat (4) rd(`JFP_SEL_DATA, v);
    chk(18'(n_rd - s), 18'h2);
    op(`JFP_SEL_CTRL, 1'b1, 18'h00001, 8);
    op(`JFP_SEL_PTR, 1'b1, 18'h08000, 16);
    rd(`JFP_SEL_DATA, v);
    rd(`JFP_SEL_DATA, v);
    chk(v[1:0], 18'h2);
    // a clean read first, so only the refusal can raise the fail flag
    op(`JFP_SEL_PTR, 1'b1, 18'h00020, 16);
    rd(`JFP_SEL_DATA, v);
    op(`JFP_SEL_SCALE, 1'b1, 18'h0000f, 8);
    s = n_rd;
    rd(`JFP_SEL_DATA, v);
    rd(`JFP_SEL_DATA, v);
    chk(18'(n_rd - s), 18'h0);
    chk(v[1:0], 18'h2);
    op(`JFP_SEL_SCALE, 1'b1, 18'h00003, 8);
    op(`JFP_SEL_CTRL, 1'b1, 18'h00020, 8);
    s = n_er;
    op(`JFP_SEL_DATA, 1'b1, 18'h0005a, 8);
    chk(18'(n_er - s), 18'h0);
    op(`JFP_SEL_DATA, 1'b1, 18'h000a5, 8);
    chk(18'(n_er - s), 18'h1);
    rd(`JFP_SEL_PTR, v);
    chk(v, 18'h00020);
    op(`JFP_SEL_CTRL, 1'b1, 18'h00001, 8);
    rd(`JFP_SEL_DATA, v);
    rd(`JFP_SEL_DATA, v);
    chk(v, 18'h003fc);
    end_of_test();
  end
endmodule
